// ===== rtl/vbc_config_regs.sv
`timescale 1ns/1ps
`include "vbc_defines.svh"

// Function
// R01 - Two-bit lane field picks four, three, two or one lanes; resets to one.
// R02 - Clear strict bit tolerates one leader bit error; set rejects any error.
// R03 - Data lane equaliser code: 00 none, 01 1 dB, 11 2 dB, 10 reserved.
// R04 - Clock lane equaliser code with the same meanings, default none.
// R05 - Clock band code in 5 MHz steps, 0x08 to 0x64 valid, rest reserved.
// R06 - Software keeps reserved lane register bits 7 and 6:5 at reset values.
// R07 - Data enable invert clear drives enable high in active video, else low.
// R08 - Line sync invert resets to 1, giving low sync; clear gives high sync.
// R09 - Frame sync invert resets to 1, giving low sync; clear gives high sync.
// R10 - Link select 0 enables both output channels A and B.
// R11 - Link select 1, the default, enables channel A only.
// R12 - All registers read and written through the local serial slave port.
// R13 - Reset restores all defaults; reads return the stored field values.
module vbc_config_regs #(
    parameter logic [6:0] SLAVE_ADDR = 7'h2C
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire vbc_pkg::vbc_vid_t vid_in,
    output vbc_pkg::vbc_vid_t vid_out,
    input wire logic leader_done,
    input wire logic [1:0] leader_err_bits,
    output logic leader_ok,
    output logic leader_bad,
    output vbc_pkg::vbc_cfg_t cfg
);
    logic rst_m_q;
    logic rst_n_q;
    vbc_pkg::vbc_state_t s_q;
    vbc_pkg::vbc_state_t s_d;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] rd_data;
    logic [7:0] rd_next;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    assign scl_rise = s_q.scl_s && !s_q.scl_p;
    assign scl_fall = !s_q.scl_s && s_q.scl_p;
    assign start_c = s_q.scl_s && s_q.scl_p && s_q.sda_p && !s_q.sda_s;
    assign stop_c = s_q.scl_s && s_q.scl_p && !s_q.sda_p && s_q.sda_s;

    function automatic logic [7:0] reg_read(input vbc_pkg::vbc_state_t st,
                                            input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `VBC_OFS_LANE: v = st.input_lane_config;
            `VBC_OFS_EQ: v = st.input_equalizer_config;
            `VBC_OFS_BAND: v = st.input_clock_band;
            `VBC_OFS_OUT: v = st.output_sync_and_link_config;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    assign rd_data = reg_read(s_q, s_q.sub); // [R13]
    assign rd_next = reg_read(s_q, s_q.sub + 8'h01);

    always_comb begin
        s_d = s_q;
        if (clk_en) begin
            s_d.scl_m = scl_i;
            s_d.scl_s = s_q.scl_m;
            s_d.scl_p = s_q.scl_s;
            s_d.sda_m = sda_i;
            s_d.sda_s = s_q.sda_m;
            s_d.sda_p = s_q.sda_s;
            // Output polarity applied in the pixel path
            s_d.vid.de = vid_in.de ^ s_q.output_sync_and_link_config[`VBC_DE_INV]; // [R07]
            s_d.vid.hs = vid_in.hs ^ s_q.output_sync_and_link_config[`VBC_HS_INV]; // [R08]
            s_d.vid.vs = vid_in.vs ^ s_q.output_sync_and_link_config[`VBC_VS_INV]; // [R09]
            s_d.leader_ok = 1'b0;
            s_d.leader_bad = 1'b0;
            if (leader_done) begin
                if (leader_err_bits == 2'h0 || (leader_err_bits == 2'h1
                        && !s_q.input_lane_config[`VBC_STRICT])) begin
                    s_d.leader_ok = 1'b1; // [R02]
                end else begin
                    s_d.leader_bad = 1'b1; // [R02]
                end
            end
            if (start_c) begin
                s_d.phase = vbc_pkg::ST_ADDR;
                s_d.bit_cnt = 4'h0;
                s_d.sda_drv = 1'b0;
            end else if (stop_c) begin
                s_d.phase = vbc_pkg::ST_IDLE;
                s_d.sda_drv = 1'b0;
            end else if (scl_rise) begin
                unique case (s_q.phase)
                    vbc_pkg::ST_ADDR, vbc_pkg::ST_SUB, vbc_pkg::ST_WR: begin
                        s_d.shreg = {s_q.shreg[6:0], s_q.sda_s};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end
                    vbc_pkg::ST_RD: s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    vbc_pkg::ST_RD_ACK: begin
                        if (s_q.sda_s) begin
                            s_d.phase = vbc_pkg::ST_IDLE;
                        end
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                unique case (s_q.phase)
                    vbc_pkg::ST_ADDR: begin
                        if (s_q.bit_cnt == 4'h8) begin
                            if (s_q.shreg[7:1] == SLAVE_ADDR) begin
                                s_d.phase = vbc_pkg::ST_ADDR_ACK;
                                s_d.rd_mode = s_q.shreg[0];
                                s_d.sda_drv = 1'b1;
                            end else begin
                                s_d.phase = vbc_pkg::ST_IDLE;
                            end
                        end
                    end
                    vbc_pkg::ST_ADDR_ACK: begin
                        s_d.bit_cnt = 4'h0;
                        if (s_q.rd_mode) begin
                            s_d.phase = vbc_pkg::ST_RD;
                            s_d.shreg = rd_data; // [R12]
                            s_d.sda_drv = !rd_data[7];
                        end else begin
                            s_d.phase = vbc_pkg::ST_SUB;
                            s_d.sda_drv = 1'b0;
                        end
                    end
                    vbc_pkg::ST_SUB: begin
                        if (s_q.bit_cnt == 4'h8) begin
                            s_d.sub = s_q.shreg;
                            s_d.phase = vbc_pkg::ST_SUB_ACK;
                            s_d.sda_drv = 1'b1;
                        end
                    end
                    vbc_pkg::ST_SUB_ACK, vbc_pkg::ST_WR_ACK: begin
                        s_d.phase = vbc_pkg::ST_WR;
                        s_d.bit_cnt = 4'h0;
                        s_d.sda_drv = 1'b0;
                    end
                    vbc_pkg::ST_WR: begin
                        if (s_q.bit_cnt == 4'h8) begin
                            // Undefined bits are not stored and read zero
                            unique case (s_q.sub)
                                `VBC_OFS_LANE: s_d.input_lane_config =
                                    s_q.shreg & `VBC_MASK_LANE; // [R01] [R06]
                                `VBC_OFS_EQ: s_d.input_equalizer_config =
                                    s_q.shreg & `VBC_MASK_EQ; // [R03] [R04]
                                `VBC_OFS_BAND: s_d.input_clock_band =
                                    s_q.shreg & `VBC_MASK_BAND; // [R05]
                                `VBC_OFS_OUT: s_d.output_sync_and_link_config =
                                    s_q.shreg & `VBC_MASK_OUT; // [R12]
                                default: ;
                            endcase
                            s_d.sub = s_q.sub + 8'h01;
                            s_d.phase = vbc_pkg::ST_WR_ACK;
                            s_d.sda_drv = 1'b1;
                        end
                    end
                    vbc_pkg::ST_RD: begin
                        if (s_q.bit_cnt == 4'h8) begin
                            s_d.phase = vbc_pkg::ST_RD_ACK;
                            s_d.sda_drv = 1'b0;
                        end else begin
                            s_d.shreg = {s_q.shreg[6:0], 1'b0};
                            s_d.sda_drv = !s_q.shreg[6];
                        end
                    end
                    vbc_pkg::ST_RD_ACK: begin
                        s_d.sub = s_q.sub + 8'h01;
                        s_d.shreg = rd_next;
                        s_d.sda_drv = !rd_next[7];
                        s_d.bit_cnt = 4'h0;
                        s_d.phase = vbc_pkg::ST_RD;
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q <= '0;
            s_q.phase <= vbc_pkg::ST_IDLE;
            s_q.scl_m <= 1'b1;
            s_q.scl_s <= 1'b1;
            s_q.scl_p <= 1'b1;
            s_q.sda_m <= 1'b1;
            s_q.sda_s <= 1'b1;
            s_q.sda_p <= 1'b1;
            s_q.input_lane_config <= `VBC_RST_LANE; // [R13]
            s_q.input_equalizer_config <= `VBC_RST_EQ;
            s_q.input_clock_band <= `VBC_RST_BAND;
            s_q.output_sync_and_link_config <= `VBC_RST_OUT;
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = s_q.sda_drv;
    assign vid_out = s_q.vid;
    assign leader_ok = s_q.leader_ok;
    assign leader_bad = s_q.leader_bad;

    always_comb begin
        cfg.lane_count_sel = s_q.input_lane_config[`VBC_LANE_SEL];
        cfg.active_lanes = 3'h4 - {1'b0, cfg.lane_count_sel}; // [R01]
        cfg.strict_leader_check = s_q.input_lane_config[`VBC_STRICT];
        cfg.data_lane_equalizer = s_q.input_equalizer_config[`VBC_DATA_EQ]; // [R03]
        cfg.clock_lane_equalizer = s_q.input_equalizer_config[`VBC_CLK_EQ]; // [R04]
        cfg.input_clock_band_code = s_q.input_clock_band;
        cfg.band_valid = s_q.input_clock_band >= `VBC_BAND_MIN
            && s_q.input_clock_band <= `VBC_BAND_MAX; // [R05]
        cfg.active_video_invert = s_q.output_sync_and_link_config[`VBC_DE_INV];
        cfg.line_sync_invert = s_q.output_sync_and_link_config[`VBC_HS_INV];
        cfg.frame_sync_invert = s_q.output_sync_and_link_config[`VBC_VS_INV];
        cfg.cha_en = 1'b1; // [R10] [R11]
        cfg.chb_en = !s_q.output_sync_and_link_config[`VBC_LINK_SEL]; // [R10] [R11]
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    lane_map_a: assert property ( // [R01]
        cfg.active_lanes == (cfg.lane_count_sel == 2'h0 ? 3'h4
            : cfg.lane_count_sel == 2'h1 ? 3'h3
            : cfg.lane_count_sel == 2'h2 ? 3'h2 : 3'h1))
        else $error("lane count mismatch");
    leader_tol_a: assert property ( // [R02]
        clk_en && leader_done && leader_err_bits == 2'h1 && !cfg.strict_leader_check
        |=> leader_ok && !leader_bad)
        else $error("single error leader not accepted");
    leader_strict_a: assert property ( // [R02]
        clk_en && leader_done && leader_err_bits != 2'h0 && cfg.strict_leader_check
        |=> leader_bad && !leader_ok)
        else $error("strict leader not rejected");
    eq_reserved_a: assert property ( // [R03]
        s_q.input_equalizer_config[5:4] == 2'h0 && s_q.input_equalizer_config[1:0] == 2'h0)
        else $error("equaliser undefined bits set");
    band_valid_a: assert property ( // [R05]
        cfg.band_valid |-> cfg.input_clock_band_code inside {[8'h08:8'h64]})
        else $error("band valid out of range");
    de_pol_a: assert property ( // [R07]
        clk_en && rst_n_q
        |=> vid_out.de == ($past(vid_in.de) ^ $past(cfg.active_video_invert)))
        else $error("data enable polarity wrong");
    hs_pol_a: assert property ( // [R08]
        clk_en && rst_n_q
        |=> vid_out.hs == ($past(vid_in.hs) ^ $past(cfg.line_sync_invert)))
        else $error("line sync polarity wrong");
    vs_pol_a: assert property ( // [R09]
        clk_en && rst_n_q
        |=> vid_out.vs == ($past(vid_in.vs) ^ $past(cfg.frame_sync_invert)))
        else $error("frame sync polarity wrong");
    link_mode_a: assert property ( // [R10]
        cfg.cha_en && (cfg.chb_en == !s_q.output_sync_and_link_config[`VBC_LINK_SEL]))
        else $error("link channel enables wrong");
    reset_def_a: assert property ( // [R13]
        $past(!rst_n_q) |-> cfg.lane_count_sel == 2'h3 && cfg.line_sync_invert
        && cfg.frame_sync_invert && !cfg.chb_en && !cfg.active_video_invert)
        else $error("defaults wrong after reset");
    ack_drive_a: assert property ( // [R12]
        s_q.phase == vbc_pkg::ST_ADDR_ACK |-> sda_oe)
        else $error("address not acknowledged");
    idle_release_a: assert property ( // [R12]
        s_q.phase == vbc_pkg::ST_IDLE |-> !sda_oe)
        else $error("data line held while idle");
    leader_excl_a: assert property ( // [R02]
        !(leader_ok && leader_bad))
        else $error("leader accepted and rejected");
    band_reject_a: assert property ( // [R05]
        !cfg.band_valid
        |-> cfg.input_clock_band_code < 8'h08 || cfg.input_clock_band_code > 8'h64)
        else $error("valid band code flagged reserved");
    freeze_hold_a: assert property ( // [R13]
        !clk_en && rst_n_q |=> $stable(vid_out) && $stable(cfg) && $stable(sda_oe))
        else $error("state moved while clock enable low");

    wr_cov_c: cover property (s_q.phase == vbc_pkg::ST_WR_ACK);
    rd_cov_c: cover property (s_q.phase == vbc_pkg::ST_RD_ACK);
    strict_cov_c: cover property (leader_bad && cfg.strict_leader_check);
    dual_cov_c: cover property (cfg.chb_en);
    freeze_cov_c: cover property (!clk_en && rst_n_q);
endmodule

// ===== rtl/vbc_defines.svh
`ifndef VBC_DEFINES_SVH
`define VBC_DEFINES_SVH
`define VBC_OFS_LANE 8'h10
`define VBC_OFS_EQ 8'h11
`define VBC_OFS_BAND 8'h12
`define VBC_OFS_OUT 8'h18
`define VBC_MASK_LANE 8'hF9
`define VBC_MASK_EQ 8'hCC
`define VBC_MASK_BAND 8'hFF
`define VBC_MASK_OUT 8'hF0
`define VBC_RST_LANE 8'h38
`define VBC_RST_EQ 8'h00
`define VBC_RST_BAND 8'h00
`define VBC_RST_OUT 8'h70
`define VBC_LANE_SEL 4:3
`define VBC_STRICT 0
`define VBC_DATA_EQ 7:6
`define VBC_CLK_EQ 3:2
`define VBC_DE_INV 7
`define VBC_HS_INV 6
`define VBC_VS_INV 5
`define VBC_LINK_SEL 4
`define VBC_BAND_MIN 8'h08
`define VBC_BAND_MAX 8'h64
`endif

// ===== rtl/vbc_pkg.sv
package vbc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
        ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } vbc_phase_t;

    typedef struct packed {
        logic [1:0] lane_count_sel;
        logic [2:0] active_lanes;
        logic strict_leader_check;
        logic [1:0] data_lane_equalizer;
        logic [1:0] clock_lane_equalizer;
        logic [7:0] input_clock_band_code;
        logic band_valid;
        logic active_video_invert;
        logic line_sync_invert;
        logic frame_sync_invert;
        logic cha_en;
        logic chb_en;
    } vbc_cfg_t;

    typedef struct packed {
        logic de;
        logic hs;
        logic vs;
    } vbc_vid_t;

    typedef struct packed {
        vbc_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] sub;
        logic rd_mode;
        logic sda_drv;
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic [7:0] input_lane_config;
        logic [7:0] input_equalizer_config;
        logic [7:0] input_clock_band;
        logic [7:0] output_sync_and_link_config;
        vbc_vid_t vid;
        logic leader_ok;
        logic leader_bad;
    } vbc_state_t;
endpackage

// ===== verification/vbc_i2c_host.sv
`timescale 1ns/1ps
module vbc_i2c_host (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic half();
        repeat (10) @(posedge clk);
    endtask
    task automatic start();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b0;
        half();
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b1;
        half();
    endtask
    // SDA moves only while SCL is low, so no false start or stop
    task automatic clk_bit(input logic b, output logic seen);
        sda_drv <= b;
        half();
        scl <= 1'b1;
        half();
        seen = sda_line;
        scl <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], s);
        end
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    // Register write, or sub-address set then read with final NACK
    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] sub,
        input logic [7:0] wd, output logic [7:0] q, output logic ok);
        logic a0, a1, a2, s;
        start();
        put_byte({a, 1'b0}, a0);
        put_byte(sub, a1);
        if (rd) begin
            stop();
            start();
            put_byte({a, 1'b1}, a2);
            for (int i = 7; i >= 0; i--) begin
                clk_bit(1'b1, q[i]);
            end
            clk_bit(1'b1, s);
        end else begin
            put_byte(wd, a2);
        end
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

// ===== verification/video_bridge_input_output_config_tb.sv
`timescale 1ns/1ps
module video_bridge_input_output_config_tb;
    localparam logic [6:0] ADDR = 7'h2C;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic scl, sda_drv, sda_o, sda_oe, leader_ok, leader_bad, sda_line;
    logic leader_done = 1'b0;
    logic clk_en = 1'b1;
    logic [1:0] leader_err_bits = 2'b00;
    vbc_pkg::vbc_vid_t vid_in = '0;
    vbc_pkg::vbc_vid_t vid_out;
    vbc_pkg::vbc_cfg_t cfg;
    int n_mismatch = 0;
    int check_count = 0;
    // Open-drain wire with pull-up
    assign sda_line = sda_drv & ~(sda_oe & ~sda_o);
    always #4 clk = ~clk;
    vbc_config_regs #(.SLAVE_ADDR(ADDR)) dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .vid_in(vid_in),
        .vid_out(vid_out), .leader_done(leader_done), .leader_err_bits(leader_err_bits),
        .leader_ok(leader_ok), .leader_bad(leader_bad), .cfg(cfg));
    vbc_i2c_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic acc(input logic [6:0] a, input logic rd, input logic [7:0] sub,
        input logic [7:0] d, input string msg);
        logic ok;
        logic [7:0] q;
        host.xfer(a, rd, sub, d, q, ok);
        chk(8'(ok), 8'(a == ADDR), "acknowledge");
        // Unanswered read leaves the pulled-up line high
        if (rd) begin
            chk(q, (a == ADDR) ? d : 8'hFF, msg);
        end
    endtask
    task automatic finish_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic t_defaults();
        acc(ADDR, 1'b1, 8'h10, 8'h38, "lane reg reset");
        acc(ADDR, 1'b1, 8'h11, 8'h00, "eq reg reset");
        acc(ADDR, 1'b1, 8'h12, 8'h00, "band reset");
        acc(ADDR, 1'b1, 8'h18, 8'h70, "out reg reset");
        acc(ADDR, 1'b1, 8'h13, 8'h00, "unmapped read");
        acc(ADDR + 7'h01, 1'b1, 8'h10, 8'h00, "foreign address");
        chk(8'(cfg.active_lanes), 8'h01, "one lane default");
        chk(8'({cfg.cha_en, cfg.chb_en}), 8'h02, "single link default");
        chk(8'({cfg.active_video_invert, cfg.line_sync_invert, cfg.frame_sync_invert}),
            8'h03, "sync invert default");
    endtask
    task automatic t_lanes();
        for (int c = 0; c < 4; c++) begin
            acc(ADDR, 1'b0, 8'h10, {3'b001, 2'(c), 3'b000}, "");
            chk(8'(cfg.active_lanes), 8'(4 - c), "active lanes");
            acc(ADDR, 1'b1, 8'h10, {3'b001, 2'(c), 3'b000}, "lane readback");
        end
    endtask
    task automatic t_leader();
        for (int s = 0; s < 2; s++) begin
            acc(ADDR, 1'b0, 8'h10, {3'b001, 2'b11, 2'b00, 1'(s)}, "");
            for (int e = 0; e < 4; e++) begin
                leader_done <= 1'b1;
                leader_err_bits <= 2'(e);
                @(posedge clk);
                leader_done <= 1'b0;
                #1;
                chk(8'({leader_ok, leader_bad}), (e == 0 || (e == 1 && s == 0)) ? 8'h02 : 8'h01,
                    "leader verdict");
                @(posedge clk);
            end
        end
    endtask
    task automatic t_eq();
        for (int c = 0; c < 4; c++) begin
            acc(ADDR, 1'b0, 8'h11, {2'(c), 2'b11, 2'(3 - c), 2'b11}, "");
            chk(8'({cfg.data_lane_equalizer, cfg.clock_lane_equalizer}), 8'(c * 4 + 3 - c),
                "eq codes");
            acc(ADDR, 1'b1, 8'h11, {2'(c), 2'b00, 2'(3 - c), 2'b00}, "eq readback");
        end
    endtask
    task automatic t_band();
        logic [7:0] v [4] = '{8'h08, 8'h64, 8'h07, 8'h65};
        for (int i = 0; i < 4; i++) begin
            acc(ADDR, 1'b0, 8'h12, v[i], "");
            chk(cfg.input_clock_band_code, v[i], "band code");
            chk(8'(cfg.band_valid), 8'(i < 2), "band range");
            acc(ADDR, 1'b1, 8'h12, v[i], "band readback");
        end
    endtask
    task automatic t_video();
        logic [7:0] v [4] = '{8'h00, 8'hE0, 8'h10, 8'h70};
        vbc_pkg::vbc_vid_t x;
        for (int i = 0; i < 4; i++) begin
            acc(ADDR, 1'b0, 8'h18, v[i] | 8'h0F, "");
            acc(ADDR, 1'b1, 8'h18, v[i], "out readback");
            chk(8'({cfg.cha_en, cfg.chb_en}), {6'h00, 1'b1, ~v[i][4]}, "link");
            for (int p = 0; p < 8; p++) begin
                x = 3'(p);
                vid_in <= x;
                @(posedge clk);
                #1;
                chk(8'(vid_out), 8'(x ^ v[i][7:5]), "video polarity");
                @(posedge clk);
            end
        end
        // Clock enable low must hold the video flops
        clk_en <= 1'b0;
        vid_in <= 3'h5;
        repeat (2) @(posedge clk);
        #1;
        chk(8'(vid_out), 8'h04, "frozen video");
        @(posedge clk);
        clk_en <= 1'b1;
    endtask
    task automatic t_reset();
        acc(ADDR, 1'b0, 8'h11, 8'hCC, "");
        acc(ADDR, 1'b0, 8'h18, 8'h80, "");
        reset_n <= 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        acc(ADDR, 1'b1, 8'h10, 8'h38, "lane after reset");
        acc(ADDR, 1'b1, 8'h11, 8'h00, "eq after reset");
        acc(ADDR, 1'b1, 8'h18, 8'h70, "out after reset");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        t_defaults();
        t_lanes();
        t_leader();
        t_eq();
        t_band();
        t_video();
        t_reset();
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
endmodule
